// ==== verilog/tcm_pkg.sv ====
// Package: register map, mode codes and carrier types for the compare match unit
package tcm_pkg;

    // Register word indices (byte address = index * 4)
    localparam int TCM_ADDR_W = 4;
    localparam logic [3:0] TCM_REG_CTL1 = 4'h0;
    localparam logic [3:0] TCM_REG_CTL2 = 4'h1;
    localparam logic [3:0] TCM_REG_CMP1_LO = 4'h2;
    localparam logic [3:0] TCM_REG_CMP1_HI = 4'h3;
    localparam logic [3:0] TCM_REG_CMP2_LO = 4'h4;
    localparam logic [3:0] TCM_REG_CMP2_HI = 4'h5;
    localparam logic [3:0] TCM_REG_IE2 = 4'h6;
    localparam logic [3:0] TCM_REG_IF2 = 4'h7;
    localparam logic [3:0] TCM_REG_APS = 4'h8;
    localparam logic [3:0] TCM_REG_FLAGS = 4'h9;
    localparam logic [3:0] TCM_REG_CNT_LO = 4'ha;
    localparam logic [3:0] TCM_REG_CNT_HI = 4'hb;
    localparam logic [3:0] TCM_REG_TCTL = 4'hc;

    // Field positions
    localparam int TCM_CTL_W = 6;
    localparam int TCM_FLAGS_U1 = 0;
    localparam int TCM_FLAGS_U2 = 1;
    localparam int TCM_FLAGS_OVF = 2;
    localparam int TCM_TCTL_RUN = 0;
    localparam int TCM_TCTL_EXT = 1;
    localparam int TCM_APS_U2 = 0;

    // Reset values
    localparam logic [5:0] TCM_CTL_RST = 6'h00;
    localparam logic [15:0] TCM_CMP_RST = 16'h0000;
    localparam logic [15:0] TCM_CNT_RST = 16'h0000;
    localparam logic [1:0] TCM_TCTL_RST = 2'h0;

    // Mode select field encodings
    localparam logic [3:0] TCM_MODE_OFF = 4'h0;
    localparam logic [3:0] TCM_MODE_TOGGLE = 4'h2;
    localparam logic [3:0] TCM_MODE_SET = 4'h8;
    localparam logic [3:0] TCM_MODE_CLR = 4'h9;
    localparam logic [3:0] TCM_MODE_SWI = 4'ha;
    localparam logic [3:0] TCM_MODE_SPEV = 4'hb;

    // State of one compare unit
    typedef struct packed {
        logic [5:0] ctl;
        logic [15:0] cmp;
        logic latch;
        logic eq;
        logic flag;
    } tcm_unit_type;

    // One pin: data out and active-low drive enable
    typedef struct packed {
        logic o;
        logic oe_n;
    } tcm_pin_type;

endpackage

// ==== verilog/tcm_top.sv ====
// Compare match unit: two compare channels, base timer, Avalon-MM register slave
//
// Behaviour
// - Compare 16-bit value with timer count continuously; equality is a match.
// - On match, pin action follows the four-bit mode select field.
// - Every compare mode sets the unit match flag on match.
// - Mode 1010 sets flag only; pin stays under port control.
// - Mode 1011 resets the timer on match and leaves the pin alone.
// - Only unit 2 in mode 1011 starts A/D, if converter enabled.
// - Special event output rises in the very cycle equality appears.
// - Timer clears only at next timer clock tick after the trigger.
// - Trigger-caused timer clear does not set the overflow flag.
// - Rewriting compare value before that tick cancels the pending clear.
// - Clearing unit control forces compare latch low; port latch untouched.
// - Fosc/4-clocked timer holds during sleep, resumes after wake.
// - Externally clocked timer keeps counting during sleep.
// - Unit 2 output goes to one of two pins by route bit.
// - 0010 toggles, 1000 sets, 1001 clears the pin; all set flag.
// - Mode 0000 turns the unit off and clears its compare latch.
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
module tcm_top (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Avalon-MM slave
    input wire logic [tcm_pkg::TCM_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Timer clock enable and system state
    input wire logic tmr_tick_i,
    input wire logic sleep_i,
    input wire logic adc_enable_i,
    // Port data and direction latches: unit 1 pin, unit 2 pins A and B
    input wire logic [2:0] port_data_i,
    input wire logic [2:0] pin_direction_bit_i,
    // Compare pins and events
    output tcm_pkg::tcm_pin_type [2:0] compare_pin_o,
    output logic [1:0] special_event_o,
    output logic adc_start_o
);
    import tcm_pkg::*;

    tcm_unit_type [1:0] unit, next_unit;
    logic [15:0] count, next_count;
    logic [1:0] tctl, next_tctl;
    logic ie2, next_ie2;
    logic route, next_route;
    logic ovf, next_ovf;
    logic [31:0] rdata, next_rdata;
    logic wait_n, next_wait_n;
    tcm_pin_type [2:0] pin, next_pin;
    logic [1:0] spev, next_spev;
    logic adc, next_adc;

    // Modes in which the unit owns its pin
    function automatic logic drives_pin(input logic [3:0] m);
        return (m == TCM_MODE_TOGGLE) || (m == TCM_MODE_SET) || (m == TCM_MODE_CLR);
    endfunction

    // Any compare mode, i.e. one that reports matches
    function automatic logic is_compare(input logic [3:0] m);
        return drives_pin(m) || (m == TCM_MODE_SWI) || (m == TCM_MODE_SPEV);
    endfunction

    // Register index of a unit's low or high compare byte
    function automatic logic [3:0] cmp_idx(input int u, input logic hi);
        return 4'(int'(TCM_REG_CMP1_LO) + 2 * u + int'(hi));
    endfunction

    // Register read mux
    function automatic logic [31:0] read_reg(input logic [3:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            TCM_REG_CTL1: d[5:0] = unit[0].ctl;
            TCM_REG_CTL2: d[5:0] = unit[1].ctl;
            TCM_REG_CMP1_LO: d[7:0] = unit[0].cmp[7:0];
            TCM_REG_CMP1_HI: d[7:0] = unit[0].cmp[15:8];
            TCM_REG_CMP2_LO: d[7:0] = unit[1].cmp[7:0];
            TCM_REG_CMP2_HI: d[7:0] = unit[1].cmp[15:8];
            TCM_REG_IE2: d[0] = ie2;
            TCM_REG_IF2: d[0] = unit[1].flag;
            TCM_REG_APS: d[TCM_APS_U2] = route;
            TCM_REG_FLAGS: d[2:0] = {ovf, unit[1].flag, unit[0].flag};
            TCM_REG_CNT_LO: d[7:0] = count[7:0];
            TCM_REG_CNT_HI: d[7:0] = count[15:8];
            TCM_REG_TCTL: d[1:0] = tctl;
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // Next-state logic: bus access, timer, compare channels, pins
    always_comb begin
        logic wr;
        logic tmr_clear;
        logic advance;
        logic [3:0] m;
        logic hit;
        wr = 1'b0;
        tmr_clear = 1'b0;
        advance = 1'b0;
        m = 4'h0;
        hit = 1'b0;
        next_unit = unit;
        next_count = count;
        next_tctl = tctl;
        next_ie2 = ie2;
        next_route = route;
        next_ovf = ovf;
        next_rdata = rdata;
        next_wait_n = 1'b0;
        next_pin = pin;
        next_spev = 2'b00;
        next_adc = 1'b0;

        // Bus handshake: one wait cycle, then a single acknowledged cycle
        if ((avs_read_i || avs_write_i) && !wait_n) begin
            next_wait_n = 1'b1;
            next_rdata = read_reg(avs_address_i);
        end
        wr = avs_write_i && wait_n;

        // Register writes; FLAGS bits clear on written one, IF2 takes the written bit; hardware set overrides below
        if (wr) begin
            for (int u = 0; u < 2; u++) begin
                if (avs_address_i == 4'(int'(TCM_REG_CTL1) + u)) begin
                    next_unit[u].ctl = avs_writedata_i[TCM_CTL_W-1:0];
                end
                if (avs_address_i == cmp_idx(u, 1'b0)) begin
                    next_unit[u].cmp[7:0] = avs_writedata_i[7:0];
                end
                if (avs_address_i == cmp_idx(u, 1'b1)) begin
                    next_unit[u].cmp[15:8] = avs_writedata_i[7:0];
                end
            end
            unique case (avs_address_i)
                TCM_REG_IE2: next_ie2 = avs_writedata_i[0];
                TCM_REG_IF2: next_unit[1].flag = avs_writedata_i[0];
                TCM_REG_APS: next_route = avs_writedata_i[TCM_APS_U2];
                TCM_REG_FLAGS: begin
                    if (avs_writedata_i[TCM_FLAGS_U1]) next_unit[0].flag = 1'b0;
                    if (avs_writedata_i[TCM_FLAGS_U2]) next_unit[1].flag = 1'b0;
                    if (avs_writedata_i[TCM_FLAGS_OVF]) next_ovf = 1'b0;
                end
                TCM_REG_TCTL: next_tctl = avs_writedata_i[1:0];
                default: ;
            endcase
        end

        // Pending clear only while a trigger's equality still holds
        for (int u = 0; u < 2; u++) begin
            if (unit[u].ctl[3:0] == TCM_MODE_SPEV && unit[u].eq) begin
                tmr_clear = 1'b1;
            end
        end

        // Instruction-clocked timer freezes in sleep, external source keeps running
        advance = tmr_tick_i && tctl[TCM_TCTL_RUN]
            && (!sleep_i || tctl[TCM_TCTL_EXT]);
        if (advance) begin
            if (tmr_clear) begin
                next_count = TCM_CNT_RST;
            end else begin
                next_count = count + 16'h0001;
                if (count == 16'hffff) next_ovf = 1'b1;
            end
        end

        // Compare channels, evaluated on next values so equality is seen at once
        for (int u = 0; u < 2; u++) begin
            m = unit[u].ctl[3:0];
            next_unit[u].eq = (next_count == next_unit[u].cmp);
            hit = next_unit[u].eq && !unit[u].eq && is_compare(m);
            if (hit) begin
                next_unit[u].flag = 1'b1;
                unique case (m)
                    TCM_MODE_TOGGLE: next_unit[u].latch = !unit[u].latch;
                    TCM_MODE_SET: next_unit[u].latch = 1'b1;
                    TCM_MODE_CLR: next_unit[u].latch = 1'b0;
                    default: ;
                endcase
            end
            // Trigger is a level for as long as the match holds
            next_spev[u] = next_unit[u].eq && (m == TCM_MODE_SPEV);
            if (next_unit[u].ctl[3:0] == TCM_MODE_OFF) begin
                next_unit[u].latch = 1'b0;
            end
        end
        // Converter start belongs to the second unit only
        next_adc = next_spev[1] && !spev[1] && adc_enable_i;

        // Pins: port latch unless the unit owns it; enable mirrors direction bit
        for (int p = 0; p < 3; p++) begin
            next_pin[p].o = port_data_i[p];
            next_pin[p].oe_n = pin_direction_bit_i[p];
        end
        if (drives_pin(next_unit[0].ctl[3:0])) begin
            next_pin[0].o = next_unit[0].latch;
        end
        if (drives_pin(next_unit[1].ctl[3:0])) begin
            next_pin[next_route ? 2 : 1].o = next_unit[1].latch;
        end
    end

    // State registers
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            for (int u = 0; u < 2; u++) begin
                unit[u].ctl <= TCM_CTL_RST;
                unit[u].cmp <= TCM_CMP_RST;
                unit[u].latch <= 1'b0;
                unit[u].eq <= 1'b0;
                unit[u].flag <= 1'b0;
            end
            count <= TCM_CNT_RST;
            tctl <= TCM_TCTL_RST;
            ie2 <= 1'b0;
            route <= 1'b0;
            ovf <= 1'b0;
            rdata <= 32'h0000_0000;
            wait_n <= 1'b0;
            for (int p = 0; p < 3; p++) begin
                pin[p].o <= 1'b0;
                pin[p].oe_n <= 1'b1; // Released until direction bits are seen
            end
            spev <= 2'b00;
            adc <= 1'b0;
        end else begin
            unit <= next_unit;
            count <= next_count;
            tctl <= next_tctl;
            ie2 <= next_ie2;
            route <= next_route;
            ovf <= next_ovf;
            rdata <= next_rdata;
            wait_n <= next_wait_n;
            pin <= next_pin;
            spev <= next_spev;
            adc <= next_adc;
        end
    end

    // Outputs straight from flops
    assign avs_readdata_o = rdata;
    assign avs_waitrequest_o = !wait_n;
    assign compare_pin_o = pin;
    assign special_event_o = spev;
    assign adc_start_o = adc;
endmodule

// ==== sim/tcm_chk.sv ====
// Checker: bus handshake and trigger relations at the unit's ports
module tcm_chk (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Bus handshake
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    // Timer and events
    input wire logic tmr_tick_i,
    input wire logic sleep_i,
    input wire logic adc_enable_i,
    input wire logic [1:0] special_event_o,
    input wire logic adc_start_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import tcm_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    // Pending request gets its answer in the next cycle
    a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("waitrequest did not drop");
    a_wait_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    // Equality can only begin after a timer step or a register write
    a_spev_new: assert property ($rose(special_event_o[1]) |->
        $past(tmr_tick_i) || $past(avs_write_i)) else $error("trigger without cause");
    // Trigger lasts until the timer tick clears the count
    a_spev_hold: assert property (special_event_o[1] && !tmr_tick_i && !avs_write_i
        |=> special_event_o[1]) else $error("trigger dropped early");
    a_spev_clear: assert property (special_event_o[1] && tmr_tick_i && !sleep_i
        |=> !special_event_o[1]) else $error("timer not cleared at tick");
    a_adc_cause: assert property (adc_start_o |-> special_event_o[1])
        else $error("conversion start without trigger");
    a_adc_when: assert property ($rose(special_event_o[1]) && $past(adc_enable_i)
        |-> adc_start_o) else $error("conversion start missing");
    a_adc_once: assert property (adc_start_o |=> !adc_start_o)
        else $error("conversion start repeated");
    c_trigger: cover property ($rose(special_event_o[1]));
    c_adc: cover property (adc_start_o);
    c_write: cover property (avs_write_i && !avs_waitrequest_o);
endmodule

bind tcm_top tcm_chk u_chk (.clk_sys_i, .srst_i, .avs_read_i, .avs_write_i,
    .avs_waitrequest_o, .tmr_tick_i, .sleep_i, .adc_enable_i, .special_event_o, .adc_start_o);

// ==== sim/tcm_far.sv ====
// Far-side model: timer clock source and pin loads with pull-down
module tcm_far (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Pins from the unit
    input wire tcm_pkg::tcm_pin_type [2:0] pin_i,
    // Timer clock enable and pin levels
    output logic tmr_tick_o = 1'b0,
    output logic [2:0] pin_level_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import tcm_pkg::*;
    // Synchronous tick at half rate, never the raw clock
    always_ff @(posedge clk_sys_i) tmr_tick_o <= srst_i ? 1'b0 : !tmr_tick_o;
    // Released pins fall to the pull-down level
    always_comb for (int p = 0; p < 3; p++) pin_level_o[p] = pin_i[p].oe_n ? 1'b0 : pin_i[p].o;
endmodule

// ==== sim/tb.sv ====
// Testbench: registers, compare modes, trigger and flags
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tcm_pkg::*;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic tmr_tick_i;
    logic sleep_i = 1'b0;
    logic adc_enable_i = 1'b1;
    logic [2:0] port_data_i = 3'h0;
    logic [2:0] pin_direction_bit_i = 3'h7;
    tcm_pin_type [2:0] compare_pin_o;
    logic [1:0] special_event_o;
    logic adc_start_o;
    logic [2:0] pin_level;
    logic [31:0] exp_q[$];
    int miscompares = 0;
    int cmp_count = 0;
    int n_adc = 0;
    int n_spev = 0;
    int exp_spev = 0;
    int exp_adc = 0;
    int seen;
    logic spev_d = 1'b0;
    logic [31:0] rnd;
    logic [6:0] ex;
    logic [3:0] rst_a[6] = '{TCM_REG_CTL1, TCM_REG_CTL2, TCM_REG_IE2, TCM_REG_IF2,
        TCM_REG_APS, TCM_REG_FLAGS};
    logic [3:0] md[7] = '{TCM_MODE_SET, TCM_MODE_TOGGLE, TCM_MODE_TOGGLE, TCM_MODE_SWI,
        TCM_MODE_OFF, TCM_MODE_TOGGLE, TCM_MODE_CLR};

    always #20 clk_sys_i = ~clk_sys_i;

    tcm_top dut (.clk_sys_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .tmr_tick_i, .sleep_i,
        .adc_enable_i, .port_data_i, .pin_direction_bit_i, .compare_pin_o,
        .special_event_o, .adc_start_o);
    tcm_far u_far (.clk_sys_i, .srst_i, .pin_i(compare_pin_o), .tmr_tick_o(tmr_tick_i),
        .pin_level_o(pin_level));

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic stop_test();
        if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // One transfer, held until waitrequest is seen low; one idle edge after
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // Timer period ends at each trigger rise; a conversion is due only when enabled
    task automatic period();
        @(posedge special_event_o[1]);
        exp_spev++;
        exp_adc += int'(adc_enable_i);
        @(posedge clk_sys_i);
    endtask

    // Read results checked in order; trigger rises and conversion starts counted
    always @(posedge clk_sys_i) begin
        spev_d <= special_event_o[1];
        if (special_event_o[1] === 1'b1 && spev_d === 1'b0) n_spev++;
        if (adc_start_o === 1'b1) n_adc++;
        if (avs_read_i && avs_waitrequest_o === 1'b0)
            chk("readdata", exp_q.pop_front(), avs_readdata_o);
    end

    initial begin
        void'($urandom(28910));
        repeat (12) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(posedge clk_sys_i);
        foreach (rst_a[i]) rd(rst_a[i], 32'h0);
        bus(1'b1, 4'hf, 32'hff);
        rd(4'hf, 32'h0);
        rnd = $urandom;
        bus(1'b1, TCM_REG_CMP1_LO, rnd);
        rd(TCM_REG_CMP1_LO, {24'h0, rnd[7:0]});
        bus(1'b1, TCM_REG_APS, rnd);
        rd(TCM_REG_APS, {31'h0, rnd[0]});
        port_data_i <= rnd[10:8];
        pin_direction_bit_i <= 3'h0;
        // Unit 2 sets a 0x40 period; unit 1 matches at 0x10 inside it
        bus(1'b1, TCM_REG_CMP2_LO, 32'h40);
        bus(1'b1, TCM_REG_CTL2, {28'h0, TCM_MODE_SPEV});
        bus(1'b1, TCM_REG_CMP1_LO, 32'h10);
        bus(1'b1, TCM_REG_TCTL, 32'h1);
        ex = {1'b0, 1'b1, rnd[8], rnd[8], 1'b1, 1'b0, 1'b1};
        period();
        // Exactly one unit 1 match per mode; toggles show any repeat
        for (int i = 0; i < 7; i++) begin
            adc_enable_i <= rnd[16 + i];
            bus(1'b1, TCM_REG_CTL1, {28'h0, md[i]});
            period();
            chk("pin0", {31'h0, ex[i]}, {31'h0, pin_level[0]});
        end
        // Asleep at the trigger: count holds, and moving the compare drops the clear
        sleep_i <= 1'b1;
        bus(1'b1, TCM_REG_CMP2_LO, 32'h41);
        rd(TCM_REG_CNT_LO, 32'h40);
        sleep_i <= 1'b0;
        seen = n_spev;
        repeat (6) @(posedge clk_sys_i);
        exp_spev++;
        exp_adc += int'(adc_enable_i);
        chk("resume_trigger", seen + 1, n_spev);
        bus(1'b1, TCM_REG_FLAGS, 32'h7);
        period();
        rd(TCM_REG_FLAGS, 32'h3);
        rd(TCM_REG_IF2, 32'h1);
        bus(1'b1, TCM_REG_CTL1, 32'h0);
        rd(TCM_REG_CTL1, 32'h0);
        // Unit 2 now sets its routed pin; unit 1 takes over the period
        bus(1'b1, TCM_REG_CTL2, {28'h0, TCM_MODE_SET});
        bus(1'b1, TCM_REG_CMP1_LO, 32'h50);
        bus(1'b1, TCM_REG_CTL1, {28'h0, TCM_MODE_SPEV});
        @(posedge special_event_o[0]);
        @(posedge clk_sys_i);
        ex = {4'h0, rnd[0] ? {1'b1, rnd[9]} : {rnd[10], 1'b1}, rnd[8]};
        chk("pins", {25'h0, ex}, {29'h0, pin_level});
        chk("triggers", exp_spev, n_spev);
        chk("adc_starts", exp_adc, n_adc);
        stop_test();
    end

    // Watchdog well beyond the expected run of about 1400 cycles
    initial begin
        #400000;
        miscompares++;
        stop_test();
    end
endmodule
